// ===== e1cp_config_regs.sv
// E1 configuration and custom pulse register bank with line pin timing
//
// Contract
// [RULE1] Bit 7 of configuration control high puts the device in E1 mode.
// [RULE2] Bit 4 low enables the line front-end, high gives framer-only operation.
// [RULE3] In framer-only mode receive line data is sampled on each extracted clock rise.
// [RULE4] In framer-only mode transmit line data is launched on each backplane clock rise.
// [RULE5] Bit 3 low sets the loss threshold to 40 dB below nominal, high to 20 dB.
// [RULE6] Bit 1 high routes the milliwatt sequence to test channels, low the PRBS path.
// [RULE7] Software writes zero to the reserved config, enable and pulse word bits.
// [RULE8] Software keeps enable bit 7 at one and bits 6-4 at zero.
// [RULE9] With custom pulse select low, marks use ROM templates chosen by build-out.
// [RULE10] With custom pulse select high, each of four phases uses its pulse word.
// [RULE11] Pulse word 1 bits 6-0 set the first phase magnitude, larger is louder.
// [RULE12] Pulse word 2 bits 6-0 set the second phase magnitude, larger is louder.
// [RULE13] Pulse word 3 at 0x1e bits 6-0 set the third phase magnitude.
// [RULE14] Pulse word 4 at 0x1f bits 6-0 set the fourth phase magnitude.
// [RULE15] All registers are eight bits and read back; pulse words are idle when unselected.
//
// The implementer's own choice: the APB register port.
`timescale 1ns/100ps
module e1cp_config_regs #(
   parameter int ADDR_W = 8,
   parameter int BCLK_HALF = e1cp_pkg::BCLK_HALF_CYC
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   output logic e1_mode,
   output logic line_frontend_disable,
   output logic loss_threshold_20db,
   output logic milliwatt_select,
   output logic prbs_select,
   output logic custom_pulse_select,
   input wire logic [2:0] line_build_out,
   input wire logic mark_active,
   input wire logic [1:0] mark_phase,
   output logic [6:0] driver_magnitude,
   input wire logic extracted_line_clock,
   input wire logic line_rx_pos,
   input wire logic line_rx_neg,
   output logic rx_pos_data,
   output logic rx_neg_data,
   output logic rx_strobe,
   input wire logic tx_pos_data,
   input wire logic tx_neg_data,
   output logic tx_take,
   output logic backplane_clock_out,
   output logic line_tx_pos,
   output logic line_tx_neg
);
   localparam int SYNC_N = e1cp_pkg::SYNC_STAGES;
   localparam int REG_W = e1cp_pkg::REG_W;
   localparam int MAG_W = e1cp_pkg::MAG_W;
   localparam int CNT_W = $clog2(BCLK_HALF + 1);

   // Register bank state
   logic [REG_W-1:0] config_r;
   logic [REG_W-1:0] config_nxt;
   logic [REG_W-1:0] pulse_en_r;
   logic [REG_W-1:0] pulse_en_nxt;
   logic [REG_W-1:0] word_r [e1cp_pkg::PHASES];
   logic [REG_W-1:0] word_nxt [e1cp_pkg::PHASES];
   logic [31:0] prdata_r;
   logic [31:0] prdata_nxt;

   // Decode helpers
   logic [5:0] idx;
   logic aligned;
   logic mapped;
   logic wr_en;
   logic rd_setup;
   logic [REG_W-1:0] rd_value;

   // Pulse shaping state
   logic mark_d_r;
   logic mark_d_nxt;
   logic [1:0] phase_d_r;
   logic [1:0] phase_d_nxt;
   logic [MAG_W-1:0] mag_r;
   logic [MAG_W-1:0] mag_nxt;
   e1cp_rom_if rom_bus ();

   // Receive pin state
   logic [SYNC_N-1:0] rclk_sync_r;
   logic [SYNC_N-1:0] rclk_sync_nxt;
   logic [SYNC_N-1:0] rpos_sync_r;
   logic [SYNC_N-1:0] rpos_sync_nxt;
   logic [SYNC_N-1:0] rneg_sync_r;
   logic [SYNC_N-1:0] rneg_sync_nxt;
   logic rclk_lvl_r;
   logic rclk_lvl_nxt;
   logic rx_pos_r;
   logic rx_pos_nxt;
   logic rx_neg_r;
   logic rx_neg_nxt;
   logic rx_stb_r;
   logic rx_stb_nxt;
   logic rclk_rise;

   // Transmit pin state
   logic [CNT_W-1:0] bcnt_r;
   logic [CNT_W-1:0] bcnt_nxt;
   logic bclk_r;
   logic bclk_nxt;
   logic tx_pos_r;
   logic tx_pos_nxt;
   logic tx_neg_r;
   logic tx_neg_nxt;
   logic tx_take_r;
   logic tx_take_nxt;
   logic bclk_rise;

   // APB address decode; zero-wait slave
   always_comb begin
      idx = paddr[7:2];
      aligned = (paddr[1:0] == 2'b00);
      mapped = 1'b0;
      if (aligned) begin
         unique case (idx)
            e1cp_pkg::IDX_CONFIG, e1cp_pkg::IDX_PULSE_EN,
            e1cp_pkg::IDX_WORD1, e1cp_pkg::IDX_WORD2,
            e1cp_pkg::IDX_WORD3, e1cp_pkg::IDX_WORD4: mapped = 1'b1;
            default: mapped = 1'b0;
         endcase
      end
      wr_en = psel && penable && pwrite && mapped && pstrb[0];
      rd_setup = psel && !penable && !pwrite;
   end

   assign pready = 1'b1;
   assign pslverr = psel && penable && !mapped;

   // Read-back mux, all eight bits as stored
   always_comb begin
      rd_value = '0;
      if (aligned) begin
         unique case (idx)
            e1cp_pkg::IDX_CONFIG: rd_value = config_r; // RULE15
            e1cp_pkg::IDX_PULSE_EN: rd_value = pulse_en_r; // RULE15
            e1cp_pkg::IDX_WORD1: rd_value = word_r[0];
            e1cp_pkg::IDX_WORD2: rd_value = word_r[1];
            e1cp_pkg::IDX_WORD3: rd_value = word_r[2];
            e1cp_pkg::IDX_WORD4: rd_value = word_r[3];
            default: rd_value = '0;
         endcase
      end
   end

   // Register writes and read data capture
   always_comb begin
      config_nxt = config_r;
      pulse_en_nxt = pulse_en_r;
      word_nxt = word_r;
      prdata_nxt = prdata_r;
      if (wr_en) begin
         // Reserved bits stored as written; software keeps them legal
         unique case (idx)
            e1cp_pkg::IDX_CONFIG: config_nxt = pwdata[7:0]; // RULE7
            e1cp_pkg::IDX_PULSE_EN: pulse_en_nxt = pwdata[7:0]; // RULE8
            e1cp_pkg::IDX_WORD1: word_nxt[0] = pwdata[7:0]; // RULE11
            e1cp_pkg::IDX_WORD2: word_nxt[1] = pwdata[7:0]; // RULE12
            e1cp_pkg::IDX_WORD3: word_nxt[2] = pwdata[7:0]; // RULE13
            e1cp_pkg::IDX_WORD4: word_nxt[3] = pwdata[7:0]; // RULE14
            default: config_nxt = config_r;
         endcase
      end
      if (rd_setup) begin
         prdata_nxt = {24'h000000, rd_value};
      end else if (psel && penable) begin
         prdata_nxt = prdata_r;
      end else begin
         prdata_nxt = 32'h00000000;
      end
   end

   // Register bank flops
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         config_r <= e1cp_pkg::CONFIG_RST;
         pulse_en_r <= e1cp_pkg::PULSE_EN_RST;
         for (int i = 0; i < e1cp_pkg::PHASES; i++) begin
            word_r[i] <= e1cp_pkg::WORD_RST;
         end
         prdata_r <= 32'h00000000;
      end else begin
         config_r <= config_nxt;
         pulse_en_r <= pulse_en_nxt;
         word_r <= word_nxt;
         prdata_r <= prdata_nxt;
      end
   end

   assign prdata = prdata_r;

   // Mode outputs decoded from configuration control and custom pulse enable
   assign e1_mode = config_r[e1cp_pkg::CFG_LINE_STD_BIT]; // RULE1
   assign line_frontend_disable = config_r[e1cp_pkg::CFG_FE_DIS_BIT]; // RULE2
   assign loss_threshold_20db = config_r[e1cp_pkg::CFG_LOS_THR_BIT]; // RULE5
   assign milliwatt_select = config_r[e1cp_pkg::CFG_TEST_SEQ_BIT]; // RULE6
   assign prbs_select = !config_r[e1cp_pkg::CFG_TEST_SEQ_BIT]; // RULE6
   assign custom_pulse_select = pulse_en_r[e1cp_pkg::PEN_CUSTOM_BIT];

   // Template ROM, addressed by build-out and phase
   assign rom_bus.addr = {line_build_out, mark_phase}; // RULE9

   e1cp_template_rom #(
      .DEPTH(e1cp_pkg::ROM_DEPTH)
   ) u_rom (
      .pclk(pclk),
      .presetn(presetn),
      .rom_port(rom_bus)
   );

   // Phase magnitude select; both paths take two cycles
   always_comb begin
      mark_d_nxt = mark_active && !line_frontend_disable;
      phase_d_nxt = mark_phase;
      mag_nxt = '0;
      if (mark_d_r) begin
         if (custom_pulse_select) begin
            mag_nxt = word_r[phase_d_r][MAG_W-1:0]; // RULE10
         end else begin
            mag_nxt = rom_bus.data; // RULE9 RULE15
         end
      end
   end

   // Pulse shaping flops
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mark_d_r <= 1'b0;
         phase_d_r <= 2'b00;
         mag_r <= '0;
      end else begin
         mark_d_r <= mark_d_nxt;
         phase_d_r <= phase_d_nxt;
         mag_r <= mag_nxt;
      end
   end

   assign driver_magnitude = mag_r;

   // Receive pins: three-stage sync, filtered clock edge
   always_comb begin
      rclk_sync_nxt = {rclk_sync_r[SYNC_N-2:0], extracted_line_clock};
      rpos_sync_nxt = {rpos_sync_r[SYNC_N-2:0], line_rx_pos};
      rneg_sync_nxt = {rneg_sync_r[SYNC_N-2:0], line_rx_neg};
      rclk_lvl_nxt = rclk_lvl_r;
      rclk_rise = 1'b0;
      if (rclk_sync_r[1] == rclk_sync_r[2]) begin
         rclk_lvl_nxt = rclk_sync_r[2];
         rclk_rise = rclk_sync_r[2] && !rclk_lvl_r;
      end
      rx_pos_nxt = rx_pos_r;
      rx_neg_nxt = rx_neg_r;
      rx_stb_nxt = 1'b0;
      if (rclk_rise && line_frontend_disable) begin
         rx_pos_nxt = rpos_sync_r[2]; // RULE3
         rx_neg_nxt = rneg_sync_r[2]; // RULE3
         rx_stb_nxt = 1'b1;
      end
   end

   // Receive flops
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rclk_sync_r <= '0;
         rpos_sync_r <= '0;
         rneg_sync_r <= '0;
         rclk_lvl_r <= 1'b0;
         rx_pos_r <= 1'b0;
         rx_neg_r <= 1'b0;
         rx_stb_r <= 1'b0;
      end else begin
         rclk_sync_r <= rclk_sync_nxt;
         rpos_sync_r <= rpos_sync_nxt;
         rneg_sync_r <= rneg_sync_nxt;
         rclk_lvl_r <= rclk_lvl_nxt;
         rx_pos_r <= rx_pos_nxt;
         rx_neg_r <= rx_neg_nxt;
         rx_stb_r <= rx_stb_nxt;
      end
   end

   assign rx_pos_data = rx_pos_r;
   assign rx_neg_data = rx_neg_r;
   assign rx_strobe = rx_stb_r;

   // Backplane clock divider and transmit launch
   always_comb begin
      bcnt_nxt = bcnt_r + 1'b1;
      bclk_nxt = bclk_r;
      bclk_rise = 1'b0;
      if (bcnt_r == CNT_W'(BCLK_HALF - 1)) begin
         bcnt_nxt = '0;
         bclk_nxt = !bclk_r;
         bclk_rise = !bclk_r;
      end
      tx_pos_nxt = tx_pos_r;
      tx_neg_nxt = tx_neg_r;
      tx_take_nxt = 1'b0;
      if (!line_frontend_disable) begin
         tx_pos_nxt = 1'b0;
         tx_neg_nxt = 1'b0;
      end else if (bclk_rise) begin
         tx_pos_nxt = tx_pos_data; // RULE4
         tx_neg_nxt = tx_neg_data; // RULE4
         tx_take_nxt = 1'b1;
      end
   end

   // Transmit flops
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         bcnt_r <= '0;
         bclk_r <= 1'b0;
         tx_pos_r <= 1'b0;
         tx_neg_r <= 1'b0;
         tx_take_r <= 1'b0;
      end else begin
         bcnt_r <= bcnt_nxt;
         bclk_r <= bclk_nxt;
         tx_pos_r <= tx_pos_nxt;
         tx_neg_r <= tx_neg_nxt;
         tx_take_r <= tx_take_nxt;
      end
   end

   assign backplane_clock_out = bclk_r;
   assign line_tx_pos = tx_pos_r;
   assign line_tx_neg = tx_neg_r;
   assign tx_take = tx_take_r;
endmodule

// ===== e1cp_pkg.sv
// Package of register map, field positions, reset values and timing counts
package e1cp_pkg;
   // Register indices; byte address is four times the index
   localparam logic [5:0] IDX_CONFIG = 6'h10;
   localparam logic [5:0] IDX_PULSE_EN = 6'h11;
   localparam logic [5:0] IDX_WORD1 = 6'h1c;
   localparam logic [5:0] IDX_WORD2 = 6'h1d;
   localparam logic [5:0] IDX_WORD3 = 6'h1e;
   localparam logic [5:0] IDX_WORD4 = 6'h1f;
   // Configuration control field positions
   localparam int CFG_LINE_STD_BIT = 7;
   localparam int CFG_FE_DIS_BIT = 4;
   localparam int CFG_LOS_THR_BIT = 3;
   localparam int CFG_TEST_SEQ_BIT = 1;
   // Custom pulse enable field positions
   localparam int PEN_CUSTOM_BIT = 3;
   // Pulse word magnitude field
   localparam int MAG_W = 7;
   localparam int REG_W = 8;
   localparam int PHASES = 4;
   // Reset values
   localparam logic [7:0] CONFIG_RST = 8'h80;
   localparam logic [7:0] PULSE_EN_RST = 8'h80;
   localparam logic [7:0] WORD_RST = 8'h00;
   // Clock and backplane timing
   localparam int CLK_PERIOD_PS = 4000;
   localparam int BCLK_FREQ_KHZ = 2048;
   localparam int BCLK_HALF_CYC = 1000000000 / (2 * BCLK_FREQ_KHZ * CLK_PERIOD_PS);
   // Pin synchroniser depth
   localparam int SYNC_STAGES = 3;
   // Pulse template ROM: eight build-out settings by four phases
   localparam int ROM_DEPTH = 32;
   localparam logic [6:0] ROM_TEMPLATE [0:31] = '{
      7'h20, 7'h40, 7'h30, 7'h08, 7'h24, 7'h44, 7'h34, 7'h0a,
      7'h28, 7'h48, 7'h38, 7'h0c, 7'h2c, 7'h4c, 7'h3c, 7'h0e,
      7'h18, 7'h30, 7'h24, 7'h06, 7'h1c, 7'h34, 7'h28, 7'h07,
      7'h20, 7'h38, 7'h2c, 7'h08, 7'h24, 7'h3c, 7'h30, 7'h09};
endpackage

// ===== e1cp_regs_chk.sv
// Port checker for the register bank, bound to its top module
`timescale 1ns/100ps
module e1cp_regs_chk #(
   parameter int BCLK_HALF = 2
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   input wire logic [31:0] prdata,
   input wire logic pslverr,
   input wire logic e1_mode,
   input wire logic line_frontend_disable,
   input wire logic loss_threshold_20db,
   input wire logic milliwatt_select,
   input wire logic prbs_select,
   input wire logic custom_pulse_select,
   input wire logic mark_active,
   input wire logic [6:0] driver_magnitude,
   input wire logic rx_strobe,
   input wire logic tx_pos_data,
   input wire logic tx_take,
   input wire logic backplane_clock_out,
   input wire logic line_tx_pos,
   input wire logic line_tx_neg
);
   logic bq_r;
   logic bq_nxt;
   logic [7:0] cnt_r;
   logic [7:0] cnt_nxt;
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   // Cycles since the backplane clock last moved
   always_comb begin
      bq_nxt = backplane_clock_out;
      cnt_nxt = (backplane_clock_out != bq_r) ? 8'h00 : cnt_r + 8'h01;
   end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         bq_r <= 1'b0;
         cnt_r <= 8'h00;
      end else begin
         bq_r <= bq_nxt;
         cnt_r <= cnt_nxt;
      end
   end
   // Completed writes to the two control words
   sequence s_cfg_wr;
      psel && penable && pwrite && pstrb[0] && paddr == 8'h40;
   endsequence
   sequence s_pen_wr;
      psel && penable && pwrite && pstrb[0] && paddr == 8'h44;
   endsequence
   chk_std_bit: assert property (s_cfg_wr |=> e1_mode == $past(pwdata[7]))
      else $error("line standard output wrong after write");
   chk_fe_bit: assert property (s_cfg_wr |=> line_frontend_disable == $past(pwdata[4]))
      else $error("front-end disable output wrong after write");
   chk_los_bit: assert property (s_cfg_wr |=> loss_threshold_20db == $past(pwdata[3]))
      else $error("loss threshold output wrong after write");
   chk_seq_pair: assert property (s_cfg_wr |=> milliwatt_select == $past(pwdata[1])
      && prbs_select != milliwatt_select) else $error("test sequence outputs wrong");
   chk_custom_bit: assert property (s_pen_wr |=> custom_pulse_select == $past(pwdata[3]))
      else $error("custom pulse select wrong after write");
   chk_tx_quiet: assert property (!line_frontend_disable [*2] |-> !line_tx_pos && !line_tx_neg)
      else $error("line transmit pins driven with front-end on");
   chk_tx_launch: assert property ($rose(backplane_clock_out) && $past(line_frontend_disable)
      |-> tx_take && line_tx_pos == $past(tx_pos_data)) else $error("transmit launch wrong");
   chk_mag_idle: assert property (!mark_active |-> ##2 driver_magnitude == 7'h00)
      else $error("driver magnitude nonzero without a mark");
   chk_bad_addr: assert property (psel && penable && paddr[1:0] != 2'b00
      |-> pslverr && prdata == 32'h0) else $error("misaligned access not refused");
   chk_bclk_rate: assert property (cnt_r <= BCLK_HALF)
      else $error("backplane clock half period too long");
   chk_rx_single: assert property (rx_strobe |=> !rx_strobe)
      else $error("receive strobe longer than one cycle");
endmodule
bind e1cp_config_regs e1cp_regs_chk #(.BCLK_HALF(BCLK_HALF)) u_chk (
   .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
   .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pslverr(pslverr),
   .e1_mode(e1_mode), .line_frontend_disable(line_frontend_disable),
   .loss_threshold_20db(loss_threshold_20db), .milliwatt_select(milliwatt_select),
   .prbs_select(prbs_select), .custom_pulse_select(custom_pulse_select),
   .mark_active(mark_active), .driver_magnitude(driver_magnitude), .rx_strobe(rx_strobe),
   .tx_pos_data(tx_pos_data), .tx_take(tx_take), .backplane_clock_out(backplane_clock_out),
   .line_tx_pos(line_tx_pos), .line_tx_neg(line_tx_neg));

// ===== e1cp_rom_if.sv
// Interface between pulse shaper and template ROM
`timescale 1ns/100ps
interface e1cp_rom_if;
   logic [4:0] addr;
   logic [6:0] data;
   modport requester (output addr, input data);
   modport rom (input addr, output data);
endinterface

// ===== e1cp_template_rom.sv
// Pulse template ROM with registered read data
`timescale 1ns/100ps
module e1cp_template_rom #(
   parameter int DEPTH = e1cp_pkg::ROM_DEPTH
) (
   input wire logic pclk,
   input wire logic presetn,
   e1cp_rom_if.rom rom_port
);
   logic [6:0] data_r;
   logic [6:0] data_nxt;

   // Table lookup
   always_comb begin
      data_nxt = e1cp_pkg::ROM_TEMPLATE[rom_port.addr];
   end

   // Read register
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         data_r <= 7'h00;
      end else begin
         data_r <= data_nxt;
      end
   end

   assign rom_port.data = data_r;
endmodule

// ===== tb_e1_config_custom_pulse_regs.sv
// Self-checking bench for the register bank
`timescale 1ns/100ps
module tb_e1_config_custom_pulse_regs;
   localparam logic [7:0] A_CFG = {e1cp_pkg::IDX_CONFIG, 2'b00};
   localparam logic [7:0] A_PEN = {e1cp_pkg::IDX_PULSE_EN, 2'b00};
   localparam logic [7:0] A_W1 = {e1cp_pkg::IDX_WORD1, 2'b00};
   // Short backplane half period keeps the run brief
   localparam int BH = 2;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata;
   logic [3:0] pstrb;
   logic e1_mode, line_frontend_disable, loss_threshold_20db, milliwatt_select;
   logic prbs_select, custom_pulse_select, mark_active, extracted_line_clock;
   logic [2:0] line_build_out;
   logic [1:0] mark_phase;
   logic [6:0] driver_magnitude;
   logic line_rx_pos, line_rx_neg, rx_pos_data, rx_neg_data, rx_strobe;
   logic tx_pos_data, tx_neg_data, tx_take, backplane_clock_out, line_tx_pos, line_tx_neg;
   logic [31:0] rd;
   logic er;
   int n_fail, checks, n;
   e1cp_config_regs #(.BCLK_HALF(BH)) dut (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .e1_mode(e1_mode), .line_frontend_disable(line_frontend_disable),
      .loss_threshold_20db(loss_threshold_20db), .milliwatt_select(milliwatt_select),
      .prbs_select(prbs_select), .custom_pulse_select(custom_pulse_select),
      .line_build_out(line_build_out), .mark_active(mark_active), .mark_phase(mark_phase),
      .driver_magnitude(driver_magnitude), .extracted_line_clock(extracted_line_clock),
      .line_rx_pos(line_rx_pos), .line_rx_neg(line_rx_neg), .rx_pos_data(rx_pos_data),
      .rx_neg_data(rx_neg_data), .rx_strobe(rx_strobe), .tx_pos_data(tx_pos_data),
      .tx_neg_data(tx_neg_data), .tx_take(tx_take), .backplane_clock_out(backplane_clock_out),
      .line_tx_pos(line_tx_pos), .line_tx_neg(line_tx_neg));
   // Clock at 4 ns period
   initial begin
      pclk = 1'b0;
      forever #2 pclk = ~pclk;
   end
   task cmp(input string nm, input logic [31:0] e, input logic [31:0] g);
      checks++;
      if (g !== e) begin
         n_fail++;
         $display("Error %s expected %h seen %h", nm, e, g);
      end
   endtask
   task test_done;
      $display("checks %0d n_fail %0d", checks, n_fail);
      if (n_fail == 0 && checks > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask
   task limit_chk;
      if (n >= 20) begin
         n_fail++;
         test_done;
      end
   endtask
   // One APB transfer, held until pready is sampled high
   task apb(input logic w, input logic [7:0] a, input logic [7:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= {24'h0, d};
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      @(posedge pclk);
      while (pready !== 1'b1 && n < 20) begin
         n++;
         @(posedge pclk);
      end
      limit_chk;
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task rd_chk(input logic [7:0] a, input logic [7:0] e);
      apb(1'b0, a, 8'h00);
      cmp("read data", {24'h0, e}, rd);
   endtask
   task t_reset;
      rd_chk(A_CFG, e1cp_pkg::CONFIG_RST);
      rd_chk(A_PEN, e1cp_pkg::PULSE_EN_RST);
      for (int i = 0; i < 4; i++)
         rd_chk(A_W1 + 8'(4 * i), e1cp_pkg::WORD_RST);
      cmp("e1_mode", 1, e1_mode);
   endtask
   task t_config;
      logic [7:0] v [4];
      v = '{8'h98, 8'h8a, 8'h00, 8'h80};
      foreach (v[i]) begin
         apb(1'b1, A_CFG, v[i]);
         @(posedge pclk);
         #1;
         cmp("e1_mode", v[i][7], e1_mode);
         cmp("fe_dis", v[i][4], line_frontend_disable);
         cmp("los_20db", v[i][3], loss_threshold_20db);
         cmp("milliwatt", v[i][1], milliwatt_select);
         cmp("prbs", !v[i][1], prbs_select);
         rd_chk(A_CFG, v[i]);
      end
   endtask
   // Strobe-less and misaligned writes change nothing; an unmapped read errors with zero data
   task t_refuse;
      apb(1'b1, A_W1, 8'h15);
      @(posedge pclk);
      pstrb <= 4'h0;
      apb(1'b1, A_W1, 8'h6a);
      cmp("strobe err", 0, er);
      pstrb <= 4'hf;
      apb(1'b1, A_W1 + 8'h01, 8'h55);
      cmp("misaligned err", 1, er);
      cmp("pready", 1, pready);
      rd_chk(A_W1, 8'h15);
      apb(1'b0, 8'h48, 8'h00);
      cmp("unmapped err", 1, er);
      cmp("unmapped data", 0, rd);
   endtask
   task t_pulse;
      logic [6:0] w [4];
      w = '{7'h11, 7'h22, 7'h44, 7'h7f};
      apb(1'b1, A_PEN, 8'h88);
      #1;
      cmp("custom select", 1, custom_pulse_select);
      foreach (w[i])
         apb(1'b1, A_W1 + 8'(4 * i), {1'b0, w[i]});
      for (int c = 1; c >= 0; c--) begin
         @(posedge pclk);
         line_build_out <= 3'h5;
         mark_active <= 1'b1;
         for (int p = 0; p < 4; p++) begin
            @(posedge pclk);
            mark_phase <= 2'(p);
            repeat (3) @(posedge pclk);
            #1;
            cmp("magnitude", c ? w[p] : e1cp_pkg::ROM_TEMPLATE[20 + p], driver_magnitude);
         end
         apb(1'b1, A_PEN, 8'h80);
      end
      @(posedge pclk);
      mark_active <= 1'b0;
      rd_chk(A_W1 + 8'h0c, 8'h7f);
   endtask
   task t_framer;
      apb(1'b1, A_CFG, 8'h90);
      for (int k = 0; k < 2; k++) begin
         @(posedge pclk);
         tx_pos_data <= 1'(k);
         tx_neg_data <= 1'(1 - k);
         extracted_line_clock <= 1'b0;
         line_rx_pos <= 1'(1 - k);
         line_rx_neg <= 1'(k);
         n = 0;
         do begin
            @(posedge pclk);
            #1;
            n++;
         end while (tx_take !== 1'b1 && n < 20);
         limit_chk;
         cmp("tx_pos", k, line_tx_pos);
         cmp("tx_neg", 1 - k, line_tx_neg);
         cmp("bclk", 1, backplane_clock_out);
         // Next launch comes one full backplane period later
         n = 0;
         do begin
            @(posedge pclk);
            #1;
            n++;
         end while (tx_take !== 1'b1 && n < 20);
         cmp("bclk period", 2 * BH, n);
         repeat (6) @(posedge pclk);
         extracted_line_clock <= 1'b1;
         n = 0;
         do begin
            @(posedge pclk);
            #1;
            n++;
         end while (rx_strobe !== 1'b1 && n < 20);
         limit_chk;
         cmp("rx_pos", 1 - k, rx_pos_data);
         cmp("rx_neg", k, rx_neg_data);
      end
      apb(1'b1, A_CFG, 8'h80);
      // Front-end back on: transmit pins must drop although data is still one
      repeat (2) @(posedge pclk);
      #1;
      cmp("tx quiet", 0, line_tx_pos);
   endtask
   // Reset, then the scenarios in turn
   initial begin
      {presetn, psel, penable, pwrite, paddr, pwdata, mark_active, mark_phase} = '0;
      {line_build_out, extracted_line_clock, line_rx_pos, line_rx_neg} = '0;
      {tx_pos_data, tx_neg_data, n_fail, checks} = '0;
      pstrb = 4'hf;
      repeat (6) @(posedge pclk);
      presetn <= 1'b1;
      t_reset;
      t_config;
      t_refuse;
      t_pulse;
      t_framer;
      test_done;
   end
endmodule
